// >>> rtl/sbo_ctrl.sv
// Purpose: Burst/listen sweep control, output shaping, serial write port
// Assumes: Serial clock sampled by mclk_i, so it must stay well below
//          a quarter of the master clock rate in this implementation
// Notes:   Frequency profile values arrive from on-chip registers
`timescale 1ns/1ps
module sbo_ctrl (
  input  wire logic        mclk_i,
  input  wire logic        arst_n_i,
  input  wire logic        sclk_i,
  input  wire logic        sdata_i,
  input  wire logic        frame_select_n_i,
  input  wire logic        sweep_ctrl_i,
  input  wire logic        abort_i,
  input  wire logic        standby_i,
  input  wire logic [23:0] freq_start_i,
  input  wire logic [23:0] freq_delta_i,
  input  wire logic [11:0] incr_count_i,
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [15:0] reg_rdata_o,
  output logic      [9:0]  dac_data_o,
  output logic             dac_enable_o,
  output logic             square_wave_out_o,
  output logic             sweep_marker_out_o
);

  localparam int P_SCK = 0;
  localparam int P_SD  = 1;
  localparam int P_FS  = 2;
  localparam int P_CT  = 3;
  localparam int P_AB  = 4;
  localparam int P_SB  = 5;

  logic [5:0]             sync1_ff;
  logic [5:0]             sync2_ff;
  logic [5:0]             prev_ff;
  logic [5:0]             rise;
  logic [5:0]             fall;
  logic                   run;
  logic [15:0]            shift_ff;
  logic [3:0]             bit_cnt_ff;
  logic                   commit_ff;
  logic [15:0]            last_word_ff;
  logic [11:0]            ctrl_ff;
  logic                   ext_burst;
  logic                   abort_evt;
  logic                   step_req;
  logic                   last_step;
  logic                   inc_evt;
  sbo_pkg::sbo_state_t    state_ff;
  logic [23:0]            freq_ff;
  logic [11:0]            step_cnt_ff;
  logic [23:0]            acc_ff;
  logic [2:0]             mark_cnt_ff;
  logic [2:0]             nxt_mark_cnt;
  logic [9:0]             nxt_dac;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; edges read only the second stage
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_ff <= 6'h04;
      sync2_ff <= 6'h04;
      prev_ff  <= 6'h04;
    end else begin
      sync1_ff <= {standby_i, abort_i, sweep_ctrl_i, frame_select_n_i,
                   sdata_i, sclk_i};
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
    end
  end

  assign rise = sync2_ff & ~prev_ff;
  assign fall = ~sync2_ff & prev_ff;
  // Standby stands in for the gated master clock
  assign run  = ~sync2_ff[P_SB];

  ////////////////////////////////////////////////////////////////////////
  // Serial write port
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      shift_ff   <= 16'h0000;
      bit_cnt_ff <= 4'h0;
      commit_ff  <= 1'b0;
    end else if (run) begin
      commit_ff <= 1'b0;
      // Frame high abandons a partial word
      if (sync2_ff[P_FS]) begin
        bit_cnt_ff <= 4'h0;
      end else if (fall[P_SCK]) begin
        shift_ff <= {shift_ff[14:0], sync2_ff[P_SD]};
        bit_cnt_ff <= bit_cnt_ff + 4'h1;
        if (bit_cnt_ff == 4'(sbo_pkg::WORD_BITS - 1)) begin
          commit_ff <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      last_word_ff <= 16'h0000;
      ctrl_ff      <= sbo_pkg::CTRL_RST;
    end else if (run) begin
      if (commit_ff) begin
        last_word_ff <= shift_ff;
      end
      if (commit_ff && shift_ff[15:12] == sbo_pkg::CMD_CTRL) begin
        ctrl_ff <= shift_ff[11:0];
      end else if (reg_wr_i && reg_addr_i == sbo_pkg::OFF_CTRL) begin
        ctrl_ff <= reg_wdata_i[11:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sweep sequencing
  // No interval timers here, so time-base bits have no effect
  assign ext_burst = ~ctrl_ff[sbo_pkg::CB_CW]
                   & ctrl_ff[sbo_pkg::CB_BURST_SRC]
                   & ctrl_ff[sbo_pkg::CB_INCR_SRC];
  assign abort_evt = run & rise[P_AB];
  assign step_req  = run & ~abort_evt & rise[P_CT]
                   & ((state_ff == sbo_pkg::SBO_LISTEN)
                   | (state_ff == sbo_pkg::SBO_BURST & ~ext_burst));
  assign last_step = step_cnt_ff == incr_count_i;
  assign inc_evt   = step_req & ~last_step;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_ff    <= sbo_pkg::SBO_IDLE;
      freq_ff     <= 24'h000000;
      step_cnt_ff <= 12'h000;
    end else if (run) begin
      if (abort_evt) begin
        state_ff <= sbo_pkg::SBO_IDLE;
      end else if (step_req) begin
        if (last_step) begin
          state_ff <= sbo_pkg::SBO_DONE;
        end else begin
          freq_ff     <= freq_ff + freq_delta_i;
          step_cnt_ff <= step_cnt_ff + 12'h001;
          state_ff    <= sbo_pkg::SBO_BURST;
        end
      end else begin
        unique case (state_ff)
          sbo_pkg::SBO_IDLE, sbo_pkg::SBO_DONE: begin
            if (rise[P_CT]) begin
              freq_ff     <= freq_start_i;
              step_cnt_ff <= 12'h000;
              state_ff    <= sbo_pkg::SBO_BURST;
            end
          end
          sbo_pkg::SBO_BURST: begin
            if (ext_burst && fall[P_CT]) begin
              state_ff <= sbo_pkg::SBO_LISTEN;
            end
          end
          sbo_pkg::SBO_LISTEN: begin
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Phase accumulator and DAC data
  // Each burst restarts at zero phase
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      acc_ff <= 24'h000000;
    end else if (run) begin
      if (state_ff == sbo_pkg::SBO_BURST && !abort_evt) begin
        acc_ff <= acc_ff + freq_ff;
      end else begin
        acc_ff <= 24'h000000;
      end
    end
  end

  function automatic logic [9:0] sine_of(input logic [5:0] ph);
    logic [3:0] idx;
    logic [8:0] amp;
    idx = ph[4] ? ~ph[3:0] : ph[3:0];
    amp = sbo_pkg::SINE_QTR[idx*9 +: 9];
    sine_of = ph[5] ? 10'h1ff - {1'b0, amp} : 10'h200 + {1'b0, amp};
  endfunction

  always_comb begin
    if (state_ff != sbo_pkg::SBO_BURST || abort_evt) begin
      nxt_dac = sbo_pkg::DAC_MID;
    end else if (ctrl_ff[sbo_pkg::CB_SINE]) begin
      nxt_dac = sine_of(acc_ff[23:18]);
    end else if (acc_ff[23]) begin
      nxt_dac = ~acc_ff[22:13];
    end else begin
      nxt_dac = acc_ff[22:13];
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dac_data_o        <= sbo_pkg::DAC_MID;
      dac_enable_o      <= 1'b0;
      square_wave_out_o <= 1'b0;
    end else if (run) begin
      dac_data_o        <= nxt_dac;
      dac_enable_o      <= ctrl_ff[sbo_pkg::CB_DAC_EN];
      square_wave_out_o <= ctrl_ff[sbo_pkg::CB_SQ_EN]
                         & ~dac_data_o[9];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sweep marker
  always_comb begin
    if (!run) begin
      nxt_mark_cnt = mark_cnt_ff;
    end else if (abort_evt) begin
      nxt_mark_cnt = 3'h0;
    end else if (inc_evt) begin
      nxt_mark_cnt = sbo_pkg::MARK_PULSE_CYC;
    end else if (mark_cnt_ff != 3'h0) begin
      nxt_mark_cnt = mark_cnt_ff - 3'h1;
    end else begin
      nxt_mark_cnt = 3'h0;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mark_cnt_ff        <= 3'h0;
      sweep_marker_out_o <= 1'b0;
    end else begin
      mark_cnt_ff <= nxt_mark_cnt;
      if (run) begin
        sweep_marker_out_o <= ctrl_ff[sbo_pkg::CB_MARK_EN]
          & (ctrl_ff[sbo_pkg::CB_MARK_MODE] ? nxt_mark_cnt != 3'h0
             : state_ff == sbo_pkg::SBO_DONE);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register read port; unmapped offsets read zero
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        sbo_pkg::OFF_CTRL:   reg_rdata_o <= {4'h0, ctrl_ff};
        sbo_pkg::OFF_STATUS: reg_rdata_o <= {state_ff, ~run, 1'b0,
                                             step_cnt_ff};
        sbo_pkg::OFF_WORD:   reg_rdata_o <= last_word_ff;
        default:             reg_rdata_o <= 16'h0000;
      endcase
    end else begin
      reg_rdata_o <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);

  a_abort_midscale: assert property (
    abort_evt |=> state_ff == sbo_pkg::SBO_IDLE ##1
      dac_data_o == sbo_pkg::DAC_MID)
    else $error("abort did not return output to midscale");

  a_listen_mid: assert property (
    (run && state_ff == sbo_pkg::SBO_LISTEN) |=>
      dac_data_o == sbo_pkg::DAC_MID)
    else $error("listen period not at midscale");

  a_listen_entry: assert property (
    (run && !abort_evt && ext_burst && fall[P_CT]
     && state_ff == sbo_pkg::SBO_BURST) |=>
      state_ff == sbo_pkg::SBO_LISTEN)
    else $error("control low did not end the burst");

  a_step_freq: assert property (
    inc_evt |=> state_ff == sbo_pkg::SBO_BURST
      && freq_ff == $past(freq_ff) + $past(freq_delta_i))
    else $error("rising control did not step frequency");

  a_standby_hold: assert property (
    !run |=> $stable(dac_data_o) && $stable(acc_ff)
      && $stable(state_ff))
    else $error("standby did not freeze the output");

  a_marker_pulse: assert property (
    (inc_evt && ctrl_ff[sbo_pkg::CB_MARK_EN]
     && ctrl_ff[sbo_pkg::CB_MARK_MODE] && !rise[P_SB]) |=>
      sweep_marker_out_o[*4] ##1 !sweep_marker_out_o)
    else $error("increment marker not four clocks long");

  a_marker_off: assert property (
    (run && !ctrl_ff[sbo_pkg::CB_MARK_EN]) |=> !sweep_marker_out_o)
    else $error("marker active while disabled");

  a_square_off: assert property (
    (run && !ctrl_ff[sbo_pkg::CB_SQ_EN]) |=> !square_wave_out_o)
    else $error("square output active while disabled");

  a_word_commit: assert property (
    commit_ff |-> $past(bit_cnt_ff) == 4'hf && !$past(sync2_ff[P_FS]))
    else $error("word committed outside a 16-bit frame");

  c_listen: cover property (state_ff == sbo_pkg::SBO_LISTEN);
  c_done:   cover property (state_ff == sbo_pkg::SBO_DONE);
  c_word:   cover property (commit_ff);
  c_abort:  cover property (abort_evt && state_ff != sbo_pkg::SBO_IDLE);

endmodule

// >>> pkg/sbo_pkg.sv
// Purpose: Shared constants for the sweep burst output control block
// Assumes: 100 MHz master clock, 16-bit serial words
// Notes:   Control bit positions index the 12-bit control field
package sbo_pkg;

  // Register port offsets
  localparam logic [3:0] OFF_CTRL   = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h4;
  localparam logic [3:0] OFF_WORD   = 4'h8;

  // Control field bit positions
  localparam int CB_MARK_EN   = 2;
  localparam int CB_MARK_MODE = 3;
  localparam int CB_INCR_SRC  = 5;
  localparam int CB_BURST_SRC = 6;
  localparam int CB_CW        = 7;
  localparam int CB_SQ_EN     = 8;
  localparam int CB_SINE      = 9;
  localparam int CB_DAC_EN    = 10;

  localparam logic [11:0] CTRL_RST = 12'h000;
  localparam logic [3:0]  CMD_CTRL = 4'h0;

  localparam int WORD_BITS = 16;
  localparam int ACC_W     = 24;
  localparam int DAC_W     = 10;

  localparam logic [9:0] DAC_MID = 10'h200;

  // Marker pulse length in master-clock periods
  localparam logic [2:0] MARK_PULSE_CYC = 3'h4;

  // Quarter-wave sine amplitudes, entry 0 in the low bits
  localparam logic [143:0] SINE_QTR = {
    9'h1fe, 9'h1f9, 9'h1f0, 9'h1e1, 9'h1ce, 9'h1b6, 9'h19a, 9'h17b,
    9'h157, 9'h131, 9'h107, 9'h0db, 9'h0ac, 9'h07c, 9'h04b, 9'h019};

  typedef enum logic [1:0] {
    SBO_IDLE   = 2'b00,
    SBO_BURST  = 2'b01,
    SBO_LISTEN = 2'b11,
    SBO_DONE   = 2'b10
  } sbo_state_t;

endpackage

// >>> test/sbo_host.sv
// Purpose: Host model that writes words over the serial port
// Assumes: Link clock period 160 ns, idle high outside frames
// Notes:   A released data line shows the inverse of its last bit
`timescale 1ns/1ps
module sbo_host (
  output logic sclk_o,
  output logic sdata_o,
  output logic frame_select_n_o
);
  initial begin
    sclk_o = 1'b1;
    sdata_o = 1'b0;
    frame_select_n_o = 1'b1;
  end

  // Sends the top n bits of w; fewer than 16 aborts the frame
  task automatic send(input logic [15:0] w, input int n);
    #13 frame_select_n_o = 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      sdata_o = w[i];
      #80 sclk_o = 1'b0;
      #80 sclk_o = 1'b1;
    end
    // Frame held past the last fall so the commit lands
    #80 frame_select_n_o = 1'b1;
    sdata_o = ~sdata_o;
  endtask
endmodule

// >>> test/tb.sv
// Purpose: Self-checking bench for the sweep burst output control
// Assumes: Serial writes come from the host model
// Notes:   Expected step counts are given as literals or from the loop index s to each status check
`timescale 1ns/1ps
module tb;
  logic        mclk, arst_n, sclk, sdata, fs_n, swp, abrt, stby;
  logic [23:0] fstart, fdelta;
  logic [11:0] nincr, ctrl;
  logic [3:0]  addr;
  logic [15:0] wdata, rdata, rv, w;
  logic        wr, rd, dac_en, sq, mark, p;
  logic [9:0]  dac, d0, df;
  logic [31:0] lf;
  int          n_mismatch, check_count, cyc, mk;
  logic [15:0] words[$];

  sbo_ctrl u_dut (.mclk_i(mclk), .arst_n_i(arst_n), .sclk_i(sclk),
    .sdata_i(sdata), .frame_select_n_i(fs_n), .sweep_ctrl_i(swp),
    .abort_i(abrt), .standby_i(stby), .freq_start_i(fstart),
    .freq_delta_i(fdelta), .incr_count_i(nincr), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .dac_data_o(dac), .dac_enable_o(dac_en),
    .square_wave_out_o(sq), .sweep_marker_out_o(mark));
  sbo_host u_host (.sclk_o(sclk), .sdata_o(sdata),
    .frame_select_n_o(fs_n));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic close_out();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic st(input logic [1:0] e, input int n);
    rd_reg(sbo_pkg::OFF_STATUS, rv);
    chk("state", {14'h0, e}, {14'h0, rv[15:14]});
    chk("steps", n[15:0], {4'h0, rv[11:0]});
  endtask

  // Moves the sweep pin and counts marker-high cycles afterwards
  task automatic set_swp(input logic v);
    @(posedge mclk);
    swp <= v;
    mk = 0;
    repeat (14) begin
      @(posedge mclk);
      #1 if (mark === 1'b1) mk++;
    end
  endtask

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      close_out();
    end
  end

  initial begin
    {arst_n, swp, abrt, stby, wr, rd} = 6'h0;
    {addr, wdata, n_mismatch, check_count, cyc} = '0;
    lf = 32'h8be9;
    fstart = 24'h010000;
    nincr = 12'd3;
    lf = lfsr(lf);
    fdelta = {8'h0, lf[15:0]};
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    #1 chk("dac_rst", 16'h0200, {6'h0, dac});
    rd_reg(4'hc, rv);
    chk("unmapped", 16'h0, rv);
    ////////////////////////////////////////////////////////////////////
    // Serial set-up: external burst, triangle, pulse marker, junk bits
    lf = lfsr(lf);
    ctrl = 12'h56c | {lf[2], 9'h0, lf[1:0]};
    w = {sbo_pkg::CMD_CTRL, ctrl};
    words.push_back(w);
    u_host.send(w, 16);
    repeat (2) @(posedge mclk);
    #1 chk("dac_en", 16'h1, {15'h0, dac_en});
    u_host.send(16'h0000, 8);
    rd_reg(sbo_pkg::OFF_WORD, rv);
    chk("word", words[$], rv);
    chk("dac_en2", 16'h1, {15'h0, dac_en});
    ////////////////////////////////////////////////////////////////////
    // Burst, listen and step sequence
    set_swp(1'b1);
    st(2'b01, 0);
    // Rising half of the triangle: top phase bits below the fold bit
    df = fstart[sbo_pkg::ACC_W-2 -: sbo_pkg::DAC_W];
    for (int i = 0; i < 6; i++) begin
      d0 = dac;
      p = dac[9];
      @(posedge mclk);
      #1 chk("square", {15'h0, ~p}, {15'h0, sq});
      chk("tri_step", {6'h0, df}, {6'h0, dac - d0});
    end
    // Three increments, then the fourth rise ends the sweep
    for (int s = 1; s <= 4; s++) begin
      set_swp(1'b0);
      chk("listen", 16'h0200, {6'h0, dac});
      st(2'b11, s - 1);
      set_swp(1'b1);
      chk("pulse", (s < 4) ? 16'h4 : 16'h0, mk[15:0]);
      if (s < 4) begin
        st(2'b01, s);
      end
    end
    st(2'b10, 3);
    wr_reg(sbo_pkg::OFF_CTRL, {4'h0, ctrl & 12'hff7});
    repeat (2) @(posedge mclk);
    #1 chk("end_mark", 16'h1, {15'h0, mark});
    wr_reg(sbo_pkg::OFF_CTRL, {4'h0, ctrl & 12'hff3});
    repeat (2) @(posedge mclk);
    #1 chk("mark_off", 16'h0, {15'h0, mark});
    ////////////////////////////////////////////////////////////////////
    // Abort mid-burst, then standby freeze and resume
    set_swp(1'b0);
    set_swp(1'b1);
    st(2'b01, 0);
    abrt <= 1'b1;
    repeat (6) @(posedge mclk);
    #1 chk("abort_dac", 16'h0200, {6'h0, dac});
    st(2'b00, 0);
    abrt <= 1'b0;
    set_swp(1'b0);
    set_swp(1'b1);
    stby <= 1'b1;
    repeat (6) @(posedge mclk);
    #1 d0 = dac;
    repeat (20) @(posedge mclk);
    #1 chk("frozen", {6'h0, d0}, {6'h0, dac});
    stby <= 1'b0;
    repeat (8) @(posedge mclk);
    #1 chk("resumed", 16'h1, {15'h0, dac !== d0});
    st(2'b01, 0);
    // Host resets and restarts after standby before new data
    abrt <= 1'b1;
    repeat (6) @(posedge mclk);
    abrt <= 1'b0;
    set_swp(1'b0);
    set_swp(1'b1);
    ////////////////////////////////////////////////////////////////////
    // Continuous select: pin low no longer gives a listen phase
    wr_reg(sbo_pkg::OFF_CTRL, {4'h0, (ctrl | 12'h280) & 12'heff});
    set_swp(1'b0);
    rd_reg(sbo_pkg::OFF_STATUS, rv);
    chk("no_listen", 16'h1, {15'h0, rv[15:14] == 2'b01});
    chk("sq_off", 16'h0, {15'h0, sq});
    // Sine shape: every code is a table level above or below midscale
    mk = 0;
    repeat (40) begin
      @(posedge mclk);
      #1;
      for (int k = 0; k < 16; k++) begin
        if (dac == 10'h200 + {1'b0, sbo_pkg::SINE_QTR[k*9 +: 9]}
            || dac == 10'h1ff - {1'b0, sbo_pkg::SINE_QTR[k*9 +: 9]}) begin
          mk++;
        end
      end
    end
    chk("sine_lvl", 16'h28, mk[15:0]);
    close_out();
  end
endmodule
